/* psm_clk_div.sv */
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_clk_div #(
	parameter int MAX_SEL = `PSM_DIV_MAX_SEL
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic slow_down_enable,
	input wire logic [3:0] slow_clock_divider_select,
	// Enable strobe
	output logic tick
);
	typedef struct packed {
		logic [MAX_SEL-1:0] cnt;
		logic tick;
	} psm_div_t;

	psm_div_t s_q, s_d;

	if (MAX_SEL < 1 || MAX_SEL > 15) begin : g_chk
		$error("psm_clk_div: MAX_SEL out of range");
	end

	// Reserved selections clamp to the slowest rate
	function automatic logic [MAX_SEL-1:0] div_mask(input logic [3:0] sel);
		logic [3:0] c;
		c = (32'(sel) > MAX_SEL) ? 4'(MAX_SEL) : sel;
		div_mask = MAX_SEL'((32'h1 << c) - 32'h1);
	endfunction

	always_comb begin
		s_d = s_q;
		if (!slow_down_enable) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else if (s_q.cnt >= div_mask(slow_clock_divider_select)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + MAX_SEL'(1);
			s_d.tick = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{cnt: '0, tick: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule // psm_clk_div

/* psm_ctrl.sv */
// Contract
// - After any reset the block sits in active mode on the full clock.
// - Idle stops the core clock; ungated peripherals keep running.
// - In idle the core state is frozen and port pins hold their levels.
// - Any enabled pending interrupt ends idle and resumes the core.
// - The hard reset input ends idle, also idle with slow-down.
// - A watchdog overflow in idle raises an internal reset ending idle.
// - Slow-down divides core and peripheral clocks by the chosen ratio.
// - Leaving idle never clears slow-down; software clears it itself.
// - Power-down: oscillator, PLL, regulator off, flash idle, pins held.
// - In power-down interrupts and watchdog cannot wake the block.
// - A power-down request starts entry into power-down.
// - A clock-free detector sees a falling edge on the chosen wake pins.
// - Wake source: 00 none, 01 serial receive, 10 ext interrupt, 11 both.
// - Hard reset during power-down returns the ordinary reset state.
// - Select bits choose between two receive and two interrupt pins.
// - Wake type one at entry gives a reset-like wake and pin reset.
// - Wake type zero at entry gives a fast wake; pins keep their levels.
// - Wake pin held high, then low for at least 100 ns, ends power-down.
// - Fast wake: regulator 150 us, oscillator 500 ns, PLL lock 200 us.
// - After an interrupt pin wake that interrupt is raised for service; here only on a fast wake, not after a reset-like wake.
// - A set gate bit stops the ADC, sync serial, CCU or timer 2 clock.
// - Clearing analog-on turns off the converter and its clock.
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_ctrl #(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Mode requests
	input wire logic idle_request,
	input wire logic power_down_request,
	input wire logic slow_down_enable,
	input wire logic [3:0] slow_clock_divider_select,
	// Wake configuration
	input wire logic [1:0] wake_source_select,
	input wire logic wake_with_reset_select,
	input wire logic serial_rx_input_select,
	input wire logic ext_int_input_select,
	// Peripheral clock control
	input wire logic [3:0] peripheral_clock_gate_control,
	input wire logic adc_analog_on,
	// Events
	input wire logic int_pending,
	input wire logic watchdog_overflow,
	input wire logic pll_locked,
	// Wake pins
	input wire logic rx_pin_a,
	input wire logic rx_pin_b,
	input wire logic ext_int_pin_a,
	input wire logic ext_int_pin_b,
	// Mode and clock outputs
	output psm_pkg::psm_state_t power_state,
	output logic cpu_clock_enable,
	output logic periph_clock_strobe,
	output logic [3:0] periph_clock_enable,
	output logic adc_conv_clock_enable,
	output logic adc_analog_enable,
	// Power outputs
	output logic osc_enable,
	output logic pll_enable,
	output logic flash_power_down,
	output logic main_regulator_on,
	// Port, reset and wake interrupt outputs
	output logic port_hold,
	output logic port_reset,
	output logic sys_reset_req,
	output logic wake_ext_irq
);
	import psm_pkg::*;

	localparam int REG_CYC = `PSM_REG_SETTLE_CYC;
	localparam int OSC_CYC = `PSM_OSC_SETTLE_CYC;
	localparam int PLL_CYC = `PSM_PLL_LOCK_CYC;
	localparam int RST_CYC = `PSM_RST_HOLD_CYC;

	if (CNT_W < 12 || (1 << CNT_W) <= REG_CYC ||
		(1 << CNT_W) <= PLL_CYC) begin : g_chk
		$error("psm_ctrl: CNT_W too small for the wake timings");
	end

	psm_ctrl_t s_q, s_d;
	logic tick;
	logic wake_hit;
	logic wake_by_ext;
	logic armed;

	function automatic logic [11:0] load(input int cyc);
		load = 12'(cyc - 1);
	endfunction

	assign armed = (s_q.state == ST_DOWN);

	// Slow-down is a plain software level; no mode change touches it
	psm_clk_div #(
		.MAX_SEL(`PSM_DIV_MAX_SEL)
	) u_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.slow_down_enable(slow_down_enable),
		.slow_clock_divider_select(slow_clock_divider_select),
		.tick(tick)
	);

	psm_wake_det #(
		.LOW_CYC(`PSM_WAKE_LOW_CYC)
	) u_wake (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.arm(armed),
		.wake_source_select(wake_source_select),
		.serial_rx_input_select(serial_rx_input_select),
		.ext_int_input_select(ext_int_input_select),
		.rx_pin_a(rx_pin_a),
		.rx_pin_b(rx_pin_b),
		.ext_int_pin_a(ext_int_pin_a),
		.ext_int_pin_b(ext_int_pin_b),
		.wake_hit(wake_hit),
		.wake_by_ext(wake_by_ext)
	);

	always_comb begin
		logic run;
		run = 1'b0;
		s_d = s_q;
		s_d.pll_meta = pll_locked;
		s_d.pll_sync = s_q.pll_meta;
		s_d.rst_req = 1'b0;
		s_d.wirq = 1'b0;
		case (s_q.state)
			ST_ACTIVE: begin
				// Power-down wins over a same-cycle idle request
				if (power_down_request) begin
					s_d.state = ST_DOWN;
					s_d.wake_rst = wake_with_reset_select;
				end else if (idle_request) begin
					s_d.state = ST_IDLE;
				end
				s_d.rst_req = watchdog_overflow;
			end
			ST_IDLE: begin
				if (watchdog_overflow) begin
					s_d.rst_req = 1'b1;
					s_d.state = ST_ACTIVE;
				end else if (int_pending) begin
					s_d.state = ST_ACTIVE;
				end
			end
			ST_DOWN: begin
				// Interrupt and watchdog inputs are not looked at here
				if (wake_hit) begin
					s_d.wake_ext = wake_by_ext;
					if (s_q.wake_rst) begin
						s_d.state = ST_WAKE_RST;
						s_d.cnt = load(RST_CYC);
					end else begin
						s_d.state = ST_WAKE_REG;
						s_d.cnt = load(REG_CYC);
					end
				end
			end
			ST_WAKE_REG: begin
				if (s_q.cnt == 12'h000) begin
					s_d.state = ST_WAKE_OSC;
					s_d.cnt = load(OSC_CYC);
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			ST_WAKE_OSC: begin
				if (s_q.cnt == 12'h000) begin
					s_d.state = ST_WAKE_PLL;
					s_d.cnt = load(PLL_CYC);
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			ST_WAKE_PLL: begin
				// Lock timeout bounds the wait if the lock flag never comes
				if (s_q.pll_sync || s_q.cnt == 12'h000) begin
					s_d.state = ST_ACTIVE;
					s_d.wirq = s_q.wake_ext;
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			ST_WAKE_RST: begin
				if (s_q.cnt == 12'h000) begin
					s_d.state = ST_ACTIVE;
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			default: begin
				s_d.state = ST_ACTIVE;
			end
		endcase

		// Outputs follow the next state so they line up with power_state
		run = (s_d.state == ST_ACTIVE) || (s_d.state == ST_IDLE);
		s_d.cpu_en = (s_d.state == ST_ACTIVE) && tick;
		s_d.per_stb = run && tick;
		s_d.per_en = {4{run && tick}} & ~peripheral_clock_gate_control;
		s_d.adc_an = run && adc_analog_on;
		s_d.adc_clk = s_d.per_en[`PSM_GATE_ADC] && adc_analog_on;
		s_d.reg_on = (s_d.state != ST_DOWN);
		s_d.osc = !((s_d.state == ST_DOWN) || (s_d.state == ST_WAKE_REG));
		s_d.pll = run || (s_d.state == ST_WAKE_PLL) ||
			(s_d.state == ST_WAKE_RST);
		s_d.flash_off = (s_d.state == ST_DOWN) ||
			(s_d.state == ST_WAKE_REG) ||
			(s_d.state == ST_WAKE_OSC) || (s_d.state == ST_WAKE_PLL);
		s_d.hold = (s_d.state == ST_IDLE) || s_d.flash_off;
		s_d.prst = (s_d.state == ST_WAKE_RST);
		// Request spans the whole reset-like window, first cycle included
		s_d.rst_req = s_d.rst_req || (s_d.state == ST_WAKE_RST);
	end

	// Asynchronous hard reset restores active mode from any state
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{state: ST_ACTIVE, cnt: 12'h000, wake_rst: 1'b0,
				wake_ext: 1'b0, pll_meta: 1'b0, pll_sync: 1'b0,
				cpu_en: 1'b1, per_stb: 1'b1, per_en: 4'hF, adc_clk: 1'b1,
				adc_an: 1'b1, osc: 1'b1, pll: 1'b1, flash_off: 1'b0,
				reg_on: 1'b1, hold: 1'b0, prst: 1'b0, rst_req: 1'b0,
				wirq: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign power_state = s_q.state;
	assign cpu_clock_enable = s_q.cpu_en;
	assign periph_clock_strobe = s_q.per_stb;
	assign periph_clock_enable = s_q.per_en;
	assign adc_conv_clock_enable = s_q.adc_clk;
	assign adc_analog_enable = s_q.adc_an;
	assign osc_enable = s_q.osc;
	assign pll_enable = s_q.pll;
	assign flash_power_down = s_q.flash_off;
	assign main_regulator_on = s_q.reg_on;
	assign port_hold = s_q.hold;
	assign port_reset = s_q.prst;
	assign sys_reset_req = s_q.rst_req;
	assign wake_ext_irq = s_q.wirq;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	property p_idle_cpu_off;
		(s_q.state == ST_IDLE) |-> !cpu_clock_enable;
	endproperty
	a_idle_cpu_off: assert property (p_idle_cpu_off)
		else $error("core clock running in idle");

	property p_idle_hold;
		(s_q.state == ST_IDLE) |-> port_hold && !port_reset;
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("pins not held in idle");

	property p_int_exit;
		(s_q.state == ST_IDLE) && int_pending && !watchdog_overflow
			|=> (s_q.state == ST_ACTIVE) && !sys_reset_req;
	endproperty
	a_int_exit: assert property (p_int_exit)
		else $error("interrupt did not end idle");

	property p_dog_idle;
		(s_q.state == ST_IDLE) && watchdog_overflow
			|=> sys_reset_req && (s_q.state == ST_ACTIVE);
	endproperty
	a_dog_idle: assert property (p_dog_idle)
		else $error("watchdog did not break idle");

	property p_down_power;
		(s_q.state == ST_DOWN) |-> !osc_enable && !pll_enable &&
			flash_power_down && !main_regulator_on && port_hold;
	endproperty
	a_down_power: assert property (p_down_power)
		else $error("power-down outputs wrong");

	property p_down_stay;
		(s_q.state == ST_DOWN) && !wake_hit |=> (s_q.state == ST_DOWN) &&
			!sys_reset_req;
	endproperty
	a_down_stay: assert property (p_down_stay)
		else $error("power-down left without wake");

	property p_down_enter;
		(s_q.state == ST_ACTIVE) && power_down_request |=>
			(s_q.state == ST_DOWN) &&
			(s_q.wake_rst == $past(wake_with_reset_select));
	endproperty
	a_down_enter: assert property (p_down_enter)
		else $error("power-down request not taken");

	sequence s_reg_settle;
		((s_q.state == ST_WAKE_REG) && main_regulator_on && !osc_enable) [*8];
	endsequence

	property p_fast_wake;
		$rose(s_q.state == ST_WAKE_REG) |-> s_reg_settle;
	endproperty
	a_fast_wake: assert property (p_fast_wake)
		else $error("regulator settle cut short");

	// Settle count must step down by one every cycle until it runs out
	property p_reg_time;
		(s_q.state == ST_WAKE_REG) && (s_q.cnt != 12'h000) |=>
			(s_q.state == ST_WAKE_REG) &&
			(s_q.cnt == $past(s_q.cnt) - 12'h001);
	endproperty
	a_reg_time: assert property (p_reg_time)
		else $error("regulator settle count broken");

	sequence s_rst_wake;
		((s_q.state == ST_WAKE_RST) && port_reset && sys_reset_req) [*4];
	endsequence

	property p_rst_wake;
		(s_q.state == ST_DOWN) && wake_hit && s_q.wake_rst |=> s_rst_wake
			##1 (s_q.state == ST_ACTIVE);
	endproperty
	a_rst_wake: assert property (p_rst_wake)
		else $error("reset-like wake sequence wrong");

	property p_wake_irq;
		wake_ext_irq |-> (s_q.state == ST_ACTIVE) &&
			($past(s_q.state) == ST_WAKE_PLL);
	endproperty
	a_wake_irq: assert property (p_wake_irq)
		else $error("wake interrupt outside a fast wake exit");

	property p_gate;
		peripheral_clock_gate_control[`PSM_GATE_SYNC] |=>
			!periph_clock_enable[`PSM_GATE_SYNC];
	endproperty
	a_gate: assert property (p_gate)
		else $error("gated peripheral clock running");

	property p_adc_off;
		!adc_analog_on |=> !adc_conv_clock_enable && !adc_analog_enable;
	endproperty
	a_adc_off: assert property (p_adc_off)
		else $error("converter clock with analog off");
endmodule // psm_ctrl

/* psm_defines.svh */
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

`define PSM_CLK_PERIOD_NS 50
`define PSM_WAKE_LOW_NS 100
`define PSM_WAKE_LOW_CYC \
	((`PSM_WAKE_LOW_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_REG_SETTLE_US 150
`define PSM_REG_SETTLE_CYC \
	((`PSM_REG_SETTLE_US * 1000 + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_OSC_SETTLE_NS 500
`define PSM_OSC_SETTLE_CYC \
	((`PSM_OSC_SETTLE_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_PLL_LOCK_US 200
`define PSM_PLL_LOCK_CYC ((`PSM_PLL_LOCK_US * 1000) / `PSM_CLK_PERIOD_NS)
`define PSM_RST_HOLD_CYC 4
`define PSM_WAKE_SRC_NONE 2'h0
`define PSM_WAKE_SRC_RX 2'h1
`define PSM_WAKE_SRC_EXT 2'h2
`define PSM_WAKE_SRC_BOTH 2'h3
`define PSM_GATE_ADC 0
`define PSM_GATE_SYNC 1
`define PSM_GATE_CCU 2
`define PSM_GATE_T2 3
`define PSM_DIV_MAX_SEL 11

`endif

/* psm_pkg.sv */
package psm_pkg;
	typedef enum logic [2:0] {
		ST_ACTIVE, ST_IDLE, ST_DOWN, ST_WAKE_REG, ST_WAKE_OSC,
		ST_WAKE_PLL, ST_WAKE_RST
	} psm_state_t;

	typedef struct packed {
		psm_state_t state;
		logic [11:0] cnt;
		logic wake_rst;
		logic wake_ext;
		logic pll_meta;
		logic pll_sync;
		logic cpu_en;
		logic per_stb;
		logic [3:0] per_en;
		logic adc_clk;
		logic adc_an;
		logic osc;
		logic pll;
		logic flash_off;
		logic reg_on;
		logic hold;
		logic prst;
		logic rst_req;
		logic wirq;
	} psm_ctrl_t;
endpackage

/* psm_wake_det.sv */
`timescale 1ns/1ps
`include "psm_defines.svh"
module psm_wake_det #(
	parameter int LOW_CYC = `PSM_WAKE_LOW_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic arm,
	input wire logic [1:0] wake_source_select,
	input wire logic serial_rx_input_select,
	input wire logic ext_int_input_select,
	// Pins
	input wire logic rx_pin_a,
	input wire logic rx_pin_b,
	input wire logic ext_int_pin_a,
	input wire logic ext_int_pin_b,
	// Result
	output logic wake_hit,
	output logic wake_by_ext
);
	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
		logic seen_rx;
		logic seen_ext;
		logic [3:0] cnt;
		logic hit;
		logic by_ext;
	} psm_wake_t;

	psm_wake_t s_q, s_d;
	logic rx, ext, rx_en, ext_en, low;

	if (LOW_CYC < 1 || LOW_CYC > 15) begin : g_chk
		$error("psm_wake_det: LOW_CYC out of range");
	end

	// Model on sys_clk; silicon keeps this path alive without a clock
	always_comb begin
		rx = serial_rx_input_select ? s_q.sync[1] : s_q.sync[0];
		ext = ext_int_input_select ? s_q.sync[3] : s_q.sync[2];
		rx_en = wake_source_select[0];
		ext_en = wake_source_select[1];
		low = (rx_en & s_q.seen_rx & ~rx) | (ext_en & s_q.seen_ext & ~ext);
		s_d = s_q;
		s_d.meta = {ext_int_pin_b, ext_int_pin_a, rx_pin_b, rx_pin_a};
		s_d.sync = s_q.meta;
		s_d.hit = 1'b0;
		s_d.by_ext = 1'b0;
		if (!arm) begin
			s_d.seen_rx = 1'b0;
			s_d.seen_ext = 1'b0;
			s_d.cnt = '0;
		end else begin
			// Only a falling edge counts: high must be seen first
			s_d.seen_rx = s_q.seen_rx | rx;
			s_d.seen_ext = s_q.seen_ext | ext;
			if (!low) begin
				s_d.cnt = '0;
			end else if (32'(s_q.cnt) >= LOW_CYC - 1) begin
				s_d.cnt = '0;
				s_d.hit = 1'b1;
				s_d.by_ext = ext_en & s_q.seen_ext & ~ext;
			end else begin
				s_d.cnt = s_q.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{meta: 4'hF, sync: 4'hF, seen_rx: 1'b0, seen_ext: 1'b0,
				cnt: 4'h0, hit: 1'b0, by_ext: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign wake_hit = s_q.hit;
	assign wake_by_ext = s_q.by_ext;
endmodule // psm_wake_det

/* psm_wake_src.sv */
`timescale 1ns/1ps
module psm_wake_src #(
	parameter int LOW_HOLD = 4
) (
	// Clock
	input wire logic sys_clk,
	// Bench commands and PLL enable from the DUT
	input wire logic [3:0] pin_fall,
	input wire logic [7:0] lock_delay,
	input wire logic pll_enable,
	// Pins and PLL status
	output logic rx_pin_a,
	output logic rx_pin_b,
	output logic ext_int_pin_a,
	output logic ext_int_pin_b,
	output logic pll_locked
);
	int low_cnt [4] = '{0, 0, 0, 0};
	int lock_cnt = 0;

	// Low for 200 ns, comfortably above the minimum width
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (pin_fall[i])
				low_cnt[i] <= LOW_HOLD;
			else if (low_cnt[i] > 0)
				low_cnt[i] <= low_cnt[i] - 1;
		end
		if (!pll_enable)
			lock_cnt <= 0;
		else if (lock_cnt < 255)
			lock_cnt <= lock_cnt + 1;
	end

	// Pins rest high on pull-ups outside wake pulses
	assign rx_pin_a = (low_cnt[0] == 0);
	assign rx_pin_b = (low_cnt[1] == 0);
	assign ext_int_pin_a = (low_cnt[2] == 0);
	assign ext_int_pin_b = (low_cnt[3] == 0);
	assign pll_locked = pll_enable && (lock_cnt >= int'(lock_delay));
endmodule // psm_wake_src

/* tb.sv */
`timescale 1ns/1ps
module tb;
	import psm_pkg::*;
	logic sys_clk, resetn, idle_request, power_down_request;
	logic slow_down_enable, wake_with_reset_select, adc_analog_on;
	logic serial_rx_input_select, ext_int_input_select;
	logic int_pending, watchdog_overflow, pll_locked;
	logic rx_pin_a, rx_pin_b, ext_int_pin_a, ext_int_pin_b;
	logic [3:0] slow_clock_divider_select, peripheral_clock_gate_control;
	logic [1:0] wake_source_select;
	psm_state_t power_state;
	logic cpu_clock_enable, periph_clock_strobe, adc_conv_clock_enable;
	logic adc_analog_enable, osc_enable, pll_enable, flash_power_down;
	logic main_regulator_on, port_hold, port_reset, sys_reset_req;
	logic wake_ext_irq;
	logic [3:0] periph_clock_enable, pin_fall, sel;
	logic [7:0] lock_delay, rnd;
	logic [1:0] wsrc_tab [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2};
	int pin_t [7] = '{0, 1, 2, 3, 0, 3, 2};
	int n_errors = 0;
	int n_checks = 0;
	int n, c;
	bit seen;

	psm_ctrl #(.CNT_W(12)) psm_ctrl_i (.sys_clk, .resetn, .idle_request,
		.power_down_request, .slow_down_enable, .slow_clock_divider_select,
		.wake_source_select, .wake_with_reset_select, .serial_rx_input_select,
		.ext_int_input_select, .peripheral_clock_gate_control, .adc_analog_on,
		.int_pending, .watchdog_overflow, .pll_locked, .rx_pin_a, .rx_pin_b,
		.ext_int_pin_a, .ext_int_pin_b, .power_state, .cpu_clock_enable,
		.periph_clock_strobe, .periph_clock_enable, .adc_conv_clock_enable,
		.adc_analog_enable, .osc_enable, .pll_enable, .flash_power_down,
		.main_regulator_on, .port_hold, .port_reset, .sys_reset_req,
		.wake_ext_irq);
	psm_wake_src psm_wake_src_i (.sys_clk, .pin_fall, .lock_delay,
		.pll_enable, .rx_pin_a, .rx_pin_b, .ext_int_pin_a, .ext_int_pin_b,
		.pll_locked);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic int exp_period(input logic [3:0] s);
		return (s > 4'hB) ? 2048 : (1 << s);
	endfunction

	task automatic step(input int k = 1);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			n_errors++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task automatic wait_st(input psm_state_t s, input int lim, output int k);
		k = 0;
		while (power_state !== s && k < lim) begin
			step();
			k++;
		end
	endtask
	task automatic req(input bit down);
		power_down_request = down;
		idle_request = !down;
		step();
		power_down_request = 1'b0;
		idle_request = 1'b0;
	endtask
	task automatic fire(input int p, input int w);
		pin_fall = 4'h1 << p;
		step();
		pin_fall = 4'h0;
		step(w);
	endtask
	// Second sample skips the partial period left by a divider change
	task automatic period(output int p);
		for (int r = 0; r < 2; r++) begin
			p = 0;
			while (cpu_clock_enable !== 1'b1 && p < 4100) begin
				step();
				p++;
			end
			p = 0;
			do begin
				step();
				p++;
			end while (cpu_clock_enable !== 1'b1 && p < 4100);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_errors++;
		print_verdict();
	end

	initial begin
		resetn = 1'b0;
		idle_request = 1'b0;
		power_down_request = 1'b0;
		slow_down_enable = 1'b0;
		slow_clock_divider_select = 4'h0;
		wake_source_select = 2'h0;
		wake_with_reset_select = 1'b0;
		serial_rx_input_select = 1'b0;
		ext_int_input_select = 1'b0;
		peripheral_clock_gate_control = 4'h0;
		adc_analog_on = 1'b1;
		int_pending = 1'b0;
		watchdog_overflow = 1'b0;
		pin_fall = 4'h0;
		lock_delay = 8'h14;
		rnd = 8'h2F;
		step(4);
		chk(power_state === ST_ACTIVE && osc_enable === 1'b1, "reset mode");
		resetn = 1'b1;
		step(2);
		chk(cpu_clock_enable === 1'b1 && port_hold === 1'b0, "full clock");
		req(0);
		wait_st(ST_IDLE, 4, n);
		chk(n < 4 && cpu_clock_enable === 1'b0, "idle entry");
		step(3);
		chk(periph_clock_strobe === 1'b1 && port_hold === 1'b1, "idle hold");
		int_pending = 1'b1;
		wait_st(ST_ACTIVE, 10, n);
		int_pending = 1'b0;
		step();
		chk(n < 10 && cpu_clock_enable === 1'b1, "interrupt ends idle");
		req(0);
		step(2);
		watchdog_overflow = 1'b1;
		step();
		watchdog_overflow = 1'b0;
		seen = 0;
		for (int i = 0; i < 3; i++) begin
			seen |= (sys_reset_req === 1'b1);
			step();
		end
		chk(seen && power_state === ST_ACTIVE, "watchdog ends idle");
		slow_down_enable = 1'b1;
		req(0);
		step(2);
		resetn = 1'b0;
		step();
		chk(power_state === ST_ACTIVE, "hard reset ends idle");
		resetn = 1'b1;
		for (int k = 0; k < 5; k++) begin
			rnd = lfsr(rnd);
			sel = (k == 0) ? 4'h0 : (k == 1) ? 4'hB : (k == 2) ? 4'hD :
				4'(rnd % 11);
			slow_clock_divider_select = sel;
			period(n);
			chk(n == exp_period(sel), "slow tick period");
		end
		slow_down_enable = 1'b0;
		period(n);
		chk(n == 1, "full clock back");
		slow_down_enable = 1'b1;
		slow_clock_divider_select = 4'h2;
		req(0);
		step(2);
		int_pending = 1'b1;
		wait_st(ST_ACTIVE, 10, n);
		int_pending = 1'b0;
		period(n);
		chk(n == 4, "slow kept after idle");
		slow_down_enable = 1'b0;
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			peripheral_clock_gate_control = (k == 0) ? 4'hF : rnd[3:0];
			adc_analog_on = (k == 0) ? 1'b0 : rnd[4];
			step(2);
			chk(periph_clock_enable === ~peripheral_clock_gate_control, "gate");
			chk(adc_analog_enable === adc_analog_on && adc_conv_clock_enable ===
				(adc_analog_on & ~peripheral_clock_gate_control[0]), "adc");
		end
		peripheral_clock_gate_control = 4'h0;
		adc_analog_on = 1'b1;
		req(1);
		step(2);
		for (int p = 0; p < 4; p++)
			fire(p, 10);
		chk(power_state === ST_DOWN, "no wake source");
		resetn = 1'b0;
		step();
		resetn = 1'b1;
		step();
		chk(power_state === ST_ACTIVE && main_regulator_on === 1'b1,
			"reset in power-down");
		for (int k = 0; k < 7; k++) begin
			wake_source_select = wsrc_tab[k];
			serial_rx_input_select = (pin_t[k] == 1);
			ext_int_input_select = (pin_t[k] == 3);
			wake_with_reset_select = (k == 6);
			rnd = lfsr(rnd);
			lock_delay = 8'(20 + int'(rnd[5:0]));
			step();
			req(1);
			wake_with_reset_select = (k != 6);
			wait_st(ST_DOWN, 4, n);
			chk(n < 4, "power-down entry");
			chk(osc_enable === 1'b0 && pll_enable === 1'b0 && port_hold === 1'b1
				&& main_regulator_on === 1'b0 && flash_power_down === 1'b1,
				"power-down outputs");
			int_pending = 1'b1;
			watchdog_overflow = 1'b1;
			step();
			watchdog_overflow = 1'b0;
			step(3);
			chk(power_state === ST_DOWN, "woken by event");
			int_pending = 1'b0;
			fire(pin_t[k] ^ 1, 10);
			chk(power_state === ST_DOWN, "unselected input woke");
			if (wsrc_tab[k] != 2'h3) begin
				fire(pin_t[k] ^ 2, 10);
				chk(power_state === ST_DOWN, "wrong source woke");
			end
			fire(pin_t[k], 0);
			if (k == 6) begin
				wait_st(ST_WAKE_RST, 12, n);
				chk(n < 12 && port_reset === 1'b1 && sys_reset_req === 1'b1,
					"reset-like wake");
				wait_st(ST_ACTIVE, 8, n);
				chk(n < 8 && port_reset === 1'b0, "after reset wake");
			end else begin
				wait_st(ST_WAKE_REG, 12, n);
				chk(n < 12, "falling edge wake");
				chk(port_hold === 1'b1 && main_regulator_on === 1'b1, "fast");
				wait_st(ST_WAKE_OSC, 3100, n);
				chk(n >= 2999 && n <= 3001, "regulator time");
				wait_st(ST_WAKE_PLL, 20, n);
				chk(n >= 9 && n <= 11 && pll_enable === 1'b1, "osc time");
				seen = 0;
				c = 0;
				while (power_state !== ST_ACTIVE && c < 300) begin
					step();
					c++;
					seen |= (wake_ext_irq === 1'b1);
				end
				chk(c < 300 && c >= int'(lock_delay) &&
					flash_power_down === 1'b0, "lock wait");
				chk(seen == (pin_t[k] >= 2), "ext wake irq");
			end
			step(2);
		end
		print_verdict();
	end
endmodule // tb
